// file: rtl/rdw_reset_delay_and_watchdog.sv
// reset latch, start-up delay timer, watchdog with prescaler, timeout/power-down flags
// assumes sys_rst marks a rising supply, the core gives one-cycle instruction strobes,
// and the master clear pin and watchdog fuse are asynchronous levels
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps

// Operation
// - power-up sets the reset latch and clears the delay timer.
// - delay timer counts once master clear is high, then releases reset.
// - core stays in reset while delay runs; timer ticks from rc oscillator.
// - only a rising supply resets; falling supply makes no reset.
// - watchdog time-out restarts the full start-up delay, also from sleep.
// - watchdog counts on its own rc ticks, also during sleep.
// - watchdog time-out fully resets the device, running or sleeping.
// - watchdog reset clears the active-low timeout flag, status bit 4.
// - fuse at zero disables the watchdog for as long as it stays low.
// - base period 18 ms; prescaler assigned divides up to 128.
// - watchdog clear instruction clears counter and assigned prescaler.
// - sleep instruction clears counter and assigned prescaler.
// - option bits 7:6 read zero; bits 5:0 set to ones on any reset.
// - flags after resets follow power-on, master clear and watchdog cases.
// - power-up and clear set both; time-out clears timeout; sleep sets/clears.
// - no other event changes the timeout and power-down flags.
// - master clear pulse resets without touching the flags.
// - time-out and sleep act whatever the current flag values are.
// - active-low power-down flag sits at status bit 3.
// - leaving sleep clears the watchdog counter, whatever woke it.
// - wake-up by master clear or time-out performs a full reset.
module rdw_reset_delay_and_watchdog import rdw_pkg::*; #(
    parameter int DELAY_CYCLES_TICKS = DELAY_TICKS,
    parameter int WDT_PERIOD_TICKS   = WDT_TICKS,
    parameter int TICK_CYCLES        = RC_TICK_CYCLES
) (
    // clock and power-up reset
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    // pins and straps
    input  wire logic              masterClearN,
    input  wire logic              watchdogEnableFuse,
    // instruction strobes from the core
    input  wire logic              watchdogClearInstr,
    input  wire logic              sleepInstr,
    // register port
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [DATA_W-1:0] regWrData,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output logic      [DATA_W-1:0] regRdData,
    // to the core and timer
    output logic                   coreReset,
    output logic                   sleepActive,
    output logic                   watchdogTimeout,
    output rdw_flags_s             statusFlags,
    output rdw_option_s            optionCfg
);

    localparam int DCW = $clog2(DELAY_CYCLES_TICKS + 1);
    localparam int WCW = $clog2(WDT_PERIOD_TICKS + 1);

    // ==================================================
    // input synchronisation and rc tick
    logic [1:0]    pinSync;
    logic          masterClearHigh;
    logic          fuseOn;
    logic          rcTick;

    // pin and fuse share one synchroniser; each bit is an independent level
    rdw_sync #(
        .WIDTH (2)
    ) u_sync (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .asyncIn ({watchdogEnableFuse, masterClearN}),
        .syncOut (pinSync)
    );

    assign masterClearHigh = pinSync[0];
    assign fuseOn   = pinSync[1];

    // limitation: the tick is divided down from mclk, so it halts if mclk does;
    // a silicon version would clock this divider from the private oscillator
    // tick source is free-running and ignores sleep
    rdw_tick_gen #(
        .CYCLES (TICK_CYCLES)
    ) u_tick (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .tick    (rcTick)
    );

    // ==================================================
    // state and storage
    rdw_state_e        state_q;
    rdw_state_e        state_d;
    logic [DCW-1:0]    delayCnt_q;
    logic [DCW-1:0]    delayCnt_d;
    logic [WCW-1:0]    wdtCnt_q;
    logic [WCW-1:0]    wdtCnt_d;
    logic [PRESC_W-1:0] presc_q;
    logic [PRESC_W-1:0] presc_d;
    rdw_option_s       option_q;
    rdw_option_s       option_d;
    rdw_flags_s        flags_q;
    rdw_flags_s        flags_d;
    logic [DATA_W-1:0] rdData_q;
    logic [DATA_W-1:0] rdData_d;

    // ==================================================
    // decode
    logic          inRun;
    logic          inSleep;
    logic          inDelay;
    logic          delayDone;
    logic          latchSet;
    logic          sleepGo;
    logic          clearGo;
    logic          wdtArmed;
    logic [7:0]    prescSpan;
    logic [7:0]    prescEnd;
    logic          prescWrap;
    logic          wdtStep;
    logic          wdtLast;
    logic          timeoutHit;
    logic          wdtClear;
    logic          prescClear;
    logic          optWrite;
    logic          rdOption;
    logic          rdStatus;
    logic          rdSeq;
    logic [DATA_W-1:0] statusWord;
    logic [DATA_W-1:0] seqWord;

    assign inRun     = (state_q == ST_RUN);
    assign inSleep   = (state_q == ST_SLEEP);
    assign inDelay   = (state_q == ST_DELAY);
    // a low pin overrides every state, including sleep
    assign latchSet  = !masterClearHigh;
    assign delayDone = inDelay && rcTick && (delayCnt_q == DCW'(DELAY_CYCLES_TICKS - 1));

    // instructions only execute while the core is out of reset
    assign sleepGo   = inRun && sleepInstr && !latchSet;
    assign clearGo   = inRun && watchdogClearInstr && !latchSet;

    // watchdog counts only while code runs or sleeps; held cleared in reset
    // so that one time-out cannot repeat during the restarted delay
    assign wdtArmed  = fuseOn && (inRun || inSleep) && !latchSet;

    // prescaler divides by 2**ratio when assigned to the watchdog
    // span is kept in 8 bits so that ratio 7 cannot overflow the compare
    assign prescSpan = 8'h01 << optionCfg.prescaleRatio;
    assign prescEnd  = prescSpan - 8'h01;
    assign prescWrap = ({1'b0, presc_q} == prescEnd);
    assign wdtStep   = wdtArmed && rcTick && (!option_q.prescalerAssign || prescWrap);
    assign wdtLast   = (wdtCnt_q == WCW'(WDT_PERIOD_TICKS - 1));
    // no dependence on the timeout flag value
    assign timeoutHit = wdtStep && wdtLast;

    // counter cleared by clear, sleep, any wake-up, time-out and reset hold
    assign wdtClear   = clearGo || sleepGo || timeoutHit || !wdtArmed;
    assign prescClear = option_q.prescalerAssign && wdtClear;

    // ==================================================
    // sequencer
    always_comb begin
        state_d    = state_q;
        delayCnt_d = delayCnt_q;
        case (state_q)
            ST_WAIT: begin
                delayCnt_d = '0;
                if (masterClearHigh) begin
                    state_d = ST_DELAY;
                end
            end
            ST_DELAY: begin
                // counts rc ticks, not core clocks
                if (rcTick) begin
                    delayCnt_d = delayCnt_q + DCW'(1);
                end
                if (delayDone) begin
                    state_d    = ST_RUN;
                    delayCnt_d = '0;
                end
            end
            ST_RUN: begin
                if (timeoutHit) begin
                    state_d    = ST_DELAY;
                    delayCnt_d = '0;
                end else if (sleepGo) begin
                    state_d = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                // wake-up goes through the full delay, never resumes
                if (timeoutHit) begin
                    state_d    = ST_DELAY;
                    delayCnt_d = '0;
                end
            end
            default: begin
                state_d    = ST_WAIT;
                delayCnt_d = '0;
            end
        endcase
        if (latchSet) begin
            state_d    = ST_WAIT;
            delayCnt_d = '0;
        end
    end

    // the only power-on source is sys_rst; nothing watches a falling supply
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_q    <= ST_WAIT;
            delayCnt_q <= '0;
        end else begin
            state_q    <= state_d;
            delayCnt_q <= delayCnt_d;
        end
    end

    // ==================================================
    // watchdog counter and prescaler
    // a ratio change takes effect at once; a count already past the new end runs on to rollover first; software should clear after it
    always_comb begin
        wdtCnt_d = wdtCnt_q;
        presc_d  = presc_q;
        if (wdtClear) begin
            wdtCnt_d = '0;
        end else if (wdtStep) begin
            wdtCnt_d = wdtCnt_q + WCW'(1);
        end
        if (prescClear) begin
            presc_d = '0;
        end else if (wdtArmed && rcTick && option_q.prescalerAssign) begin
            presc_d = prescWrap ? '0 : presc_q + PRESC_W'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wdtCnt_q <= '0;
            presc_q  <= '0;
        end else begin
            wdtCnt_q <= wdtCnt_d;
            presc_q  <= presc_d;
        end
    end

    // ==================================================
    // timeout and power-down flags
    // time-out outranks a clear or sleep in the same cycle
    always_comb begin
        flags_d = flags_q;
        if (timeoutHit) begin
            flags_d.timeoutFlagN = 1'b0;
        end else if (sleepGo) begin
            flags_d.timeoutFlagN   = 1'b1;
            flags_d.powerdownFlagN = 1'b0;
        end else if (clearGo) begin
            flags_d = FLAGS_POWERUP;
        end
    end

    // master clear never reaches this register
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            flags_q <= FLAGS_POWERUP;
        end else begin
            flags_q <= flags_d;
        end
    end

    // ==================================================
    // option register
    // writes are dropped during any reset, as the forced ones must win
    assign optWrite = regWr && (regAddr == OFS_OPTION);

    always_comb begin
        option_d = option_q;
        if (coreReset) begin
            option_d = OPTION_RESET;
        end else if (optWrite) begin
            option_d = regWrData[5:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            option_q <= OPTION_RESET;
        end else begin
            option_q <= option_d;
        end
    end

    // ==================================================
    // read path
    // every bit not placed below reads as zero
    assign rdOption = regRd && (regAddr == OFS_OPTION);
    assign rdStatus = regRd && (regAddr == OFS_STATUS);
    assign rdSeq    = regRd && (regAddr == OFS_SEQ);

    always_comb begin
        statusWord                = '0;
        statusWord[TIMEOUT_BIT]   = flags_q.timeoutFlagN;
        statusWord[POWERDOWN_BIT] = flags_q.powerdownFlagN;
        seqWord                   = '0;
        seqWord[SEQ_RESET_BIT]    = coreReset;
        seqWord[SEQ_SLEEP_BIT]    = inSleep;
        seqWord[SEQ_STATE_LSB +: 2] = state_q;
    end

    // option is write-only and reads as zero, as do unmapped offsets
    always_comb begin
        rdData_d = '0;
        if (rdStatus) begin
            rdData_d = statusWord;
        end else if (rdSeq) begin
            rdData_d = seqWord;
        end else if (rdOption) begin
            rdData_d = '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdData_q <= '0;
        end else begin
            rdData_q <= rdData_d;
        end
    end

    // ==================================================
    // outputs
    // the delay only protects start-up; supply validity relies on the pin
    // coreReset decodes the state register only, so pin noise cannot glitch it
    assign coreReset       = !(inRun || inSleep);
    assign sleepActive     = inSleep;
    assign watchdogTimeout = timeoutHit;
    assign statusFlags     = flags_q;
    assign optionCfg       = option_q;
    assign regRdData       = rdData_q;

endmodule : rdw_reset_delay_and_watchdog

// file: rtl/rdw_pkg.sv
// shared constants and carrier types of the reset delay and watchdog block
// assumes a single 50 MHz system clock and a plain register port
package rdw_pkg;

    // ==================================================
    // register port
    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 8;
    localparam logic [3:0]  OFS_OPTION      = 4'h0;
    localparam logic [3:0]  OFS_STATUS      = 4'h1;
    localparam logic [3:0]  OFS_SEQ         = 4'h2;

    // ==================================================
    // field positions and reset values
    localparam int          TIMEOUT_BIT     = 4;
    localparam int          POWERDOWN_BIT   = 3;
    localparam int          SEQ_RESET_BIT   = 0;
    localparam int          SEQ_SLEEP_BIT   = 1;
    localparam int          SEQ_STATE_LSB   = 2;
    localparam logic [5:0]  OPTION_RESET    = 6'h3F;
    localparam logic [1:0]  FLAGS_POWERUP   = 2'h3;

    // ==================================================
    // timing
    localparam int          CLK_PERIOD_NS   = 20;
    // nominal period of the private rc oscillator, modelled as a tick
    localparam int          RC_PERIOD_NS    = 1000;
    localparam int          RC_TICK_CYCLES  = RC_PERIOD_NS / CLK_PERIOD_NS;
    localparam int          DELAY_TIME_MS   = 18;
    localparam int          WDT_TIME_MS     = 18;
    localparam int          DELAY_TICKS     = DELAY_TIME_MS * 1000000 / RC_PERIOD_NS;
    localparam int          WDT_TICKS       = WDT_TIME_MS * 1000000 / RC_PERIOD_NS;
    localparam int          PRESC_W         = 7;

    // ==================================================
    // types
    typedef struct packed {
        logic       timerClockSourceSel;
        logic       timerEdgeSel;
        logic       prescalerAssign;
        logic [2:0] prescaleRatio;
    } rdw_option_s;

    typedef struct packed {
        logic timeoutFlagN;
        logic powerdownFlagN;
    } rdw_flags_s;

    // gray along wait -> delay -> run -> sleep
    typedef enum logic [1:0] {
        ST_WAIT  = 2'b00,
        ST_DELAY = 2'b01,
        ST_RUN   = 2'b11,
        ST_SLEEP = 2'b10
    } rdw_state_e;

endpackage : rdw_pkg

// file: rtl/rdw_sync.sv
// two-flop synchroniser for asynchronous pins and straps
// assumes inputs come from outside the mclk domain
`timescale 1ns/1ps
module rdw_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    // data
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] stable_q;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            meta_q   <= '0;
            stable_q <= '0;
        end else begin
            meta_q   <= asyncIn;
            stable_q <= meta_q;
        end
    end

    assign syncOut = stable_q;

endmodule : rdw_sync

// file: rtl/rdw_tick_gen.sv
// free-running tick standing in for the private rc oscillator
// assumes mclk never stops; only power-up resets it
`timescale 1ns/1ps
module rdw_tick_gen #(
    parameter int CYCLES = 50
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic sys_rst,
    // tick
    output logic      tick
);

    localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;

    logic [CW-1:0] count_q;
    logic          last;

    assign last = (count_q == CW'(CYCLES - 1));
    assign tick = last;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            count_q <= '0;
        end else if (last) begin
            count_q <= '0;
        end else begin
            count_q <= count_q + CW'(1);
        end
    end

endmodule : rdw_tick_gen

// file: tb/rdw_chk.sv
// port-level checker for the reset delay and watchdog block
// assumes the bench counts: 2 mclk per rc tick, 4 ticks for the delay and for the watchdog
`timescale 1ns/1ps
module rdw_chk import rdw_pkg::*; #(
    parameter int DELAY_CYCLES_TICKS = 4,
    parameter int WDT_PERIOD_TICKS   = 4,
    parameter int TICK_CYCLES        = 2
) (
    // clock and reset
    input wire logic              mclk,
    input wire logic              sys_rst,
    // pins, strobes, register port
    input wire logic              masterClearN,
    input wire logic              watchdogEnableFuse,
    input wire logic              watchdogClearInstr,
    input wire logic              sleepInstr,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic              regRd,
    input wire logic [DATA_W-1:0] regRdData,
    // sequencer outputs
    input wire logic              coreReset,
    input wire logic              sleepActive,
    input wire logic              watchdogTimeout,
    input wire rdw_flags_s        statusFlags,
    input wire rdw_option_s       optionCfg
);
    // ==================================================
    // sequences
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence s_run;
        !coreReset && !sleepActive && masterClearN;
    endsequence
    sequence s_pinRise;
        $rose(masterClearN) && coreReset;
    endsequence

    // ==================================================
    // assertions; repetition counts follow the bench counts
    a_powerup_state: assert property (disable iff (1'b0)
        sys_rst |=> coreReset && !sleepActive && statusFlags == FLAGS_POWERUP && optionCfg == OPTION_RESET)
        else $error("power-up state wrong");
    a_pin_resets: assert property (!masterClearN [*4] |-> coreReset)
        else $error("pin low without core reset");
    a_delay_holds: assert property (s_pinRise |-> coreReset [*8])
        else $error("delay released early");
    a_delay_ends: assert property (s_pinRise |-> ##[9:16] !coreReset)
        else $error("delay never released");
    a_flags_cause: assert property ($changed(statusFlags) |->
        $past(watchdogTimeout || sleepInstr || watchdogClearInstr)) else $error("flags changed alone");
    a_timeout_flags: assert property (watchdogTimeout |=> !statusFlags.timeoutFlagN &&
        statusFlags.powerdownFlagN == $past(statusFlags.powerdownFlagN)) else $error("time-out flags wrong");
    a_timeout_reset: assert property (watchdogTimeout |=> coreReset && !sleepActive)
        else $error("time-out without reset");
    a_sleep_entry: assert property (s_run ##0 (sleepInstr && !watchdogTimeout) |=>
        sleepActive && statusFlags == 2'b10) else $error("sleep entry wrong");
    a_clear_holds: assert property (s_run ##0 watchdogClearInstr |=> !watchdogTimeout [*6])
        else $error("time-out too soon after clear");
    a_fuse_off: assert property (!watchdogEnableFuse [*4] |-> !watchdogTimeout)
        else $error("time-out with fuse off");
    a_status_read: assert property (regRd && regAddr == OFS_STATUS |=>
        regRdData == {3'h0, $past(statusFlags), 3'h0}) else $error("status read wrong");
    a_option_forced: assert property (coreReset [*2] |-> optionCfg == OPTION_RESET)
        else $error("option not forced in reset");
endmodule : rdw_chk

bind rdw_reset_delay_and_watchdog rdw_chk #(.DELAY_CYCLES_TICKS(DELAY_CYCLES_TICKS),
    .WDT_PERIOD_TICKS(WDT_PERIOD_TICKS), .TICK_CYCLES(TICK_CYCLES)) i_chk (.mclk(mclk), .sys_rst(sys_rst),
    .masterClearN(masterClearN), .watchdogEnableFuse(watchdogEnableFuse), .watchdogClearInstr(watchdogClearInstr),
    .sleepInstr(sleepInstr), .regAddr(regAddr), .regRd(regRd), .regRdData(regRdData), .coreReset(coreReset),
    .sleepActive(sleepActive), .watchdogTimeout(watchdogTimeout), .statusFlags(statusFlags), .optionCfg(optionCfg));

// file: tb/rdw_master_clear_n_model.sv
// model of the external reset circuit on the master clear pin
// assumes the bench drives supplyOk and clearReq just after rising edges
`timescale 1ns/1ps
module rdw_clear_source_model #(
    parameter int LOW_CYCLES = 6
) (
    // clock
    input  wire logic mclk,
    // requests from the bench
    input  wire logic supplyOk,
    input  wire logic clearReq,
    // pin
    output logic      masterClearN
);
    int lowCnt = 0;
    initial masterClearN = 1'b0;
    // a pulse shorter than the pin synchroniser would be lost, so pulses last LOW_CYCLES + 1 cycles
    always @(posedge mclk) begin
        if (clearReq) lowCnt <= LOW_CYCLES;
        else if (lowCnt > 0) lowCnt <= lowCnt - 1;
        masterClearN <= supplyOk && !clearReq && lowCnt == 0;
    end
endmodule : rdw_clear_source_model

// file: tb/rdw_tb_top.sv
// self-checking bench for the reset delay and watchdog block
// assumes the checker is bound in and the pin model sits on master clear
`timescale 1ns/1ps
module tb_top import rdw_pkg::*; ;
    logic mclk, sys_rst, watchdogEnableFuse, watchdogClearInstr, sleepInstr, regWr, regRd, supplyOk, clearReq;
    logic masterClearN, coreReset, sleepActive, watchdogTimeout;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWrData, regRdData, d;
    rdw_flags_s  statusFlags;
    rdw_option_s optionCfg;
    int n_mismatch = 0;
    int checks = 0;
    int n;

    rdw_clear_source_model #(.LOW_CYCLES(6)) i_pin (.mclk(mclk), .supplyOk(supplyOk), .clearReq(clearReq),
        .masterClearN(masterClearN));
    rdw_reset_delay_and_watchdog #(.DELAY_CYCLES_TICKS(4), .WDT_PERIOD_TICKS(4), .TICK_CYCLES(2)) i_dut (
        .mclk(mclk), .sys_rst(sys_rst), .masterClearN(masterClearN), .watchdogEnableFuse(watchdogEnableFuse),
        .watchdogClearInstr(watchdogClearInstr), .sleepInstr(sleepInstr), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .coreReset(coreReset),
        .sleepActive(sleepActive), .watchdogTimeout(watchdogTimeout), .statusFlags(statusFlags),
        .optionCfg(optionCfg));

    // ==================================================
    // helpers
    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    task wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk) begin regAddr <= a; regWrData <= v; regWr <= 1'b1; end
        @(posedge mclk) regWr <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge mclk) begin regAddr <= a; regRd <= 1'b1; end
        @(posedge mclk) regRd <= 1'b0;
        #1 v = regRdData;
    endtask : rd
    task instr(input bit s);
        @(posedge mclk) if (s) sleepInstr <= 1'b1; else watchdogClearInstr <= 1'b1;
        @(posedge mclk) begin sleepInstr <= 1'b0; watchdogClearInstr <= 1'b0; end
    endtask : instr
    task pinPulse;
        @(posedge mclk) clearReq <= 1'b1;
        @(posedge mclk) clearReq <= 1'b0;
        repeat (5) @(posedge mclk);
        #1 chk("coreReset", 8'h01, coreReset);
    endtask : pinPulse
    task waitRun;
        for (n = 0; n < 100 && coreReset !== 1'b0; n++) @(posedge mclk) #1;
        chk("released", 8'h01, n < 100);
    endtask : waitRun
    // counts edges from the last strobe to the time-out pulse
    task waitTo;
        #1 n = 0;
        while (watchdogTimeout !== 1'b1 && n < 1500) begin @(posedge mclk) #1; n++; end
    endtask : waitTo

    // ==================================================
    // scenarios
    task t_powerup;
        rd(OFS_STATUS, d);
        chk("status", 8'h18, d);
        chk("coreReset", 8'h01, coreReset);
        @(posedge mclk) supplyOk <= 1'b1;
        waitRun;
        rd(OFS_SEQ, d);
        chk("seq", 8'h0C, d);
        $display("done t_powerup");
    endtask : t_powerup
    task t_regs;
        // keeps the prescaler assigned so no time-out lands inside this test
        wr(OFS_OPTION, 8'hCD);
        #1 chk("option", 8'h0D, {2'b00, optionCfg});
        rd(OFS_OPTION, d);
        chk("option read", 8'h00, d);
        rd(4'hF, d);
        chk("unmapped", 8'h00, d);
        wr(OFS_STATUS, 8'h00);
        rd(OFS_STATUS, d);
        chk("status", 8'h18, d);
        $display("done t_regs");
    endtask : t_regs
    task t_period(input logic [7:0] opt, input int exp);
        waitRun;
        wr(OFS_OPTION, opt);
        instr(1'b0);
        waitTo;
        chk("period", 8'h01, n >= exp - 2 && n <= exp + 1);
        @(posedge mclk) #1 chk("coreReset", 8'h01, coreReset);
        waitRun;
        rd(OFS_STATUS, d);
        chk("status", 8'h08, d);
        chk("option", 8'h3F, {2'b00, optionCfg});
        $display("done t_period %h", opt);
    endtask : t_period
    task t_sleep_wdt;
        waitRun;
        wr(OFS_OPTION, 8'h30);
        instr(1'b1);
        waitTo;
        chk("sleepActive", 8'h01, sleepActive);
        chk("sleep period", 8'h01, n >= 6 && n <= 9);
        @(posedge mclk) #1 chk("wake", 8'h01, coreReset && !sleepActive);
        waitRun;
        rd(OFS_STATUS, d);
        chk("status", 8'h00, d);
        $display("done t_sleep_wdt");
    endtask : t_sleep_wdt
    task t_sleep_pin;
        waitRun;
        instr(1'b0);
        instr(1'b1);
        repeat (3) @(posedge mclk);
        pinPulse;
        waitRun;
        rd(OFS_STATUS, d);
        chk("status", 8'h10, d);
        pinPulse;
        waitRun;
        rd(OFS_STATUS, d);
        chk("status", 8'h10, d);
        $display("done t_sleep_pin");
    endtask : t_sleep_pin
    task t_fuse;
        int bad;
        bad = 0;
        @(posedge mclk) watchdogEnableFuse <= 1'b0;
        wr(OFS_OPTION, 8'h30);
        repeat (300) @(posedge mclk) #1 if (watchdogTimeout !== 1'b0) bad++;
        chk("fuse off", 8'h00, {7'h00, bad != 0});
        @(posedge mclk) watchdogEnableFuse <= 1'b1;
        $display("done t_fuse");
    endtask : t_fuse

    // ==================================================
    // clock, watchdog, main sequence
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        #200us;
        n_mismatch++;
        report_and_stop;
    end
    initial begin
        {sys_rst, watchdogEnableFuse} = 2'b11;
        {watchdogClearInstr, sleepInstr, regWr, regRd, supplyOk, clearReq} = 6'h00;
        regAddr = 4'h0;
        regWrData = 8'h00;
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        t_powerup;
        t_regs;
        t_period(8'h30, 8);
        for (int r = 0; r < 4; r++) t_period(8'h08 | r[7:0], 8 << r);
        t_sleep_wdt;
        t_sleep_pin;
        t_fuse;
        report_and_stop;
    end
endmodule : tb_top
